/* hw/switch_memory_access_map.sv */
`timescale 1ns/1ns
`include "switch_memory_access_map.svh"

// Contract
// RQ1 - Top address bit one reaches memory space, zero reaches register space.
// RQ2 - Memory-select field of control register picks which memory is reached.
// RQ3 - Select 000 reaches local route table, 001 backplane route table.
// RQ4 - Address bits 13 to 9 give stream; local 0-15, backplane 0-31.
// RQ5 - At top rate only local streams 0-7, backplane streams 0-15 used.
// RQ6 - Address bits 8 to 0 give channel, up to 512 positions.
// RQ7 - Channels 0-31 at 2M, 0-63 at 4M, 0-127 at 8M.
// RQ8 - Channels 0-255 at 16M and 0-511 at 32M.
// RQ9 - Two separate data stores, backplane received and local received.
// RQ10 - Each received timeslot becomes a byte written into its side's store.
// RQ11 - Local store holds 4096 bytes addressed by stream and channel.
// RQ12 - Local store is host readable, never host writable.
// RQ13 - Data store reads return zero in bits 15:8, byte in 7:0.
// RQ14 - Local byte bit 7 holds first received bit of the timeslot.
// RQ15 - Backplane store holds 8192 bytes addressed by stream and channel.
// RQ16 - Backplane store is host readable, never host writable.
// RQ17 - Backplane byte bit 7 holds first received bit of the timeslot.
// RQ18 - Stores are 8 bits wide, widened to 16 only on read path.
// RQ19 - Host write to a data store changes nothing, bus cycle completes.

module switch_memory_access_map (
  input wire logic core_clk,
  input wire logic srst,
  input wire switch_memory_access_pkg::host_req_t host_req,
  input wire logic [2:0] memory_select_field,
  input wire switch_memory_access_pkg::rate_t local_rate,
  input wire switch_memory_access_pkg::rate_t backplane_rate,
  input wire switch_memory_access_pkg::rx_bit_t local_rx,
  input wire switch_memory_access_pkg::rx_bit_t backplane_rx,
  output logic [15:0] host_rdata,
  output logic host_ack,
  output switch_memory_access_pkg::fwd_req_t fwd_req
);

  // ----------------------------------------
  // Index and range helpers
  // ----------------------------------------
  function automatic logic chan_in_use(
    input logic [8:0] chan,
    input switch_memory_access_pkg::rate_t rate
  );
    logic [9:0] limit;
    limit = `CHAN_BASE << rate;
    return {1'b0, chan} < limit;
  endfunction : chan_in_use

  function automatic logic [`LOCAL_IDX_W-1:0] local_index(
    input logic [4:0] stream,
    input logic [8:0] chan,
    input logic hi
  );
    return hi ? {stream[2:0], chan} : {stream[3:0], chan[7:0]};
  endfunction : local_index

  function automatic logic [`BACKPLANE_IDX_W-1:0] backplane_index(
    input logic [4:0] stream,
    input logic [8:0] chan,
    input logic hi
  );
    return hi ? {stream[3:0], chan} : {stream, chan[7:0]};
  endfunction : backplane_index

  function automatic logic local_in_use(
    input logic [4:0] stream,
    input logic [8:0] chan,
    input switch_memory_access_pkg::rate_t rate
  );
    logic [4:0] limit;
    limit = (rate == switch_memory_access_pkg::RATE_32M) ? `LOCAL_STREAMS_HI : `LOCAL_STREAMS;
    return (stream < limit) && chan_in_use(chan, rate);
  endfunction : local_in_use

  function automatic logic backplane_in_use(
    input logic [4:0] stream,
    input logic [8:0] chan,
    input switch_memory_access_pkg::rate_t rate
  );
    logic stream_ok;
    stream_ok = (rate != switch_memory_access_pkg::RATE_32M) || (stream < `BACKPLANE_STREAMS_HI);
    return stream_ok && chan_in_use(chan, rate);
  endfunction : backplane_in_use

  // ----------------------------------------
  // Host address decode
  // ----------------------------------------
  wire mem_space = host_req.addr[`SPACE_SEL_BIT];
  wire [4:0] host_stream = host_req.addr[`STREAM_MSB:`STREAM_LSB];
  wire [8:0] host_chan = host_req.addr[`CHAN_MSB:`CHAN_LSB];
  wire local_hi = (local_rate == switch_memory_access_pkg::RATE_32M);
  wire backplane_hi = (backplane_rate == switch_memory_access_pkg::RATE_32M);
  wire reg_hit = host_req.valid && !mem_space; // RQ1
  wire mem_hit = host_req.valid && mem_space; // RQ1
  wire local_route_hit = mem_hit && (memory_select_field == `MS_LOCAL_ROUTE); // RQ2 RQ3
  wire backplane_route_hit = mem_hit && (memory_select_field == `MS_BACKPLANE_ROUTE); // RQ3
  wire local_data_hit = mem_hit && (memory_select_field == `MS_LOCAL_DATA); // RQ2
  wire backplane_data_hit = mem_hit && (memory_select_field == `MS_BACKPLANE_DATA); // RQ2
  wire unmapped_hit = mem_hit && !local_route_hit && !backplane_route_hit
                      && !local_data_hit && !backplane_data_hit;
  wire [`LOCAL_IDX_W-1:0] host_local_idx = local_index(host_stream, host_chan, local_hi); // RQ4 RQ6
  wire [`BACKPLANE_IDX_W-1:0] host_backplane_idx =
    backplane_index(host_stream, host_chan, backplane_hi); // RQ4 RQ6
  wire host_local_ok = local_in_use(host_stream, host_chan, local_rate); // RQ5 RQ7 RQ8
  wire host_backplane_ok = backplane_in_use(host_stream, host_chan, backplane_rate); // RQ5 RQ7 RQ8

  switch_memory_access_pkg::access_kind_t kind_next;
  assign kind_next = local_data_hit ? switch_memory_access_pkg::KIND_LOCAL_DATA :
                     backplane_data_hit ? switch_memory_access_pkg::KIND_BACKPLANE_DATA :
                     unmapped_hit ? switch_memory_access_pkg::KIND_UNMAPPED :
                     switch_memory_access_pkg::KIND_NONE;

  // Writes to a data store are answered but read back nothing
  wire rd_ok_next = !host_req.we && ((local_data_hit && host_local_ok)
                    || (backplane_data_hit && host_backplane_ok)); // RQ12 RQ16 RQ19

  // ----------------------------------------
  // Receive side: serial to byte
  // ----------------------------------------
  switch_memory_access_pkg::rx_byte_t local_byte;
  switch_memory_access_pkg::rx_byte_t backplane_byte;

  rx_serial_to_byte local_conv (
    .core_clk(core_clk),
    .srst(srst),
    .rx_in(local_rx),
    .byte_out(local_byte)
  );

  rx_serial_to_byte backplane_conv (
    .core_clk(core_clk),
    .srst(srst),
    .rx_in(backplane_rx),
    .byte_out(backplane_byte)
  );

  wire [`LOCAL_IDX_W-1:0] rx_local_idx = local_index(local_byte.stream, local_byte.chan, local_hi);
  wire [`BACKPLANE_IDX_W-1:0] rx_backplane_idx =
    backplane_index(backplane_byte.stream, backplane_byte.chan, backplane_hi);
  wire rx_local_wr = local_byte.valid && local_in_use(local_byte.stream, local_byte.chan, local_rate);
  wire rx_backplane_wr = backplane_byte.valid
                         && backplane_in_use(backplane_byte.stream, backplane_byte.chan, backplane_rate);

  // ----------------------------------------
  // Data stores, byte wide
  // ----------------------------------------
  // Only the receive path writes; the host port is read only
  logic [`BYTE_W-1:0] local_rx_byte_store [0:`LOCAL_DEPTH-1]; // RQ9 RQ11 RQ18
  logic [`BYTE_W-1:0] backplane_rx_byte_store [0:`BACKPLANE_DEPTH-1]; // RQ9 RQ15 RQ18
  logic [`BYTE_W-1:0] local_rd_reg;
  logic [`BYTE_W-1:0] backplane_rd_reg;

  always_ff @(posedge core_clk) begin
    if (rx_local_wr) begin
      local_rx_byte_store[rx_local_idx] <= local_byte.data; // RQ10 RQ12
    end
    local_rd_reg <= local_rx_byte_store[host_local_idx];
  end

  always_ff @(posedge core_clk) begin
    if (rx_backplane_wr) begin
      backplane_rx_byte_store[rx_backplane_idx] <= backplane_byte.data; // RQ10 RQ16
    end
    backplane_rd_reg <= backplane_rx_byte_store[host_backplane_idx];
  end

  // ----------------------------------------
  // Host answer pipeline
  // ----------------------------------------
  switch_memory_access_pkg::access_kind_t kind_reg;
  logic rd_ok_reg;
  logic [15:0] host_rdata_reg;
  logic host_ack_reg;
  switch_memory_access_pkg::fwd_req_t fwd_reg;
  switch_memory_access_pkg::fwd_req_t fwd_next;
  logic [15:0] host_rdata_next;

  assign fwd_next.reg_valid = reg_hit; // RQ1
  assign fwd_next.local_route_valid = local_route_hit; // RQ3
  assign fwd_next.backplane_route_valid = backplane_route_hit; // RQ3
  assign fwd_next.we = host_req.we;
  assign fwd_next.addr = host_req.addr[`STREAM_MSB:0];
  assign fwd_next.wdata = host_req.wdata;

  wire [`BYTE_W-1:0] rd_byte = (kind_reg == switch_memory_access_pkg::KIND_LOCAL_DATA) ?
                               local_rd_reg : backplane_rd_reg;
  assign host_rdata_next = rd_ok_reg ? {`UPPER_FILL, rd_byte} : 16'h0000; // RQ13 RQ18

  always_ff @(posedge core_clk) begin
    if (srst) begin
      kind_reg <= switch_memory_access_pkg::KIND_NONE;
      rd_ok_reg <= 1'b0;
      fwd_reg <= '0;
    end else begin
      kind_reg <= kind_next; // RQ2
      rd_ok_reg <= rd_ok_next;
      fwd_reg <= fwd_next;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      host_rdata_reg <= 16'h0000;
      host_ack_reg <= 1'b0;
    end else begin
      host_rdata_reg <= host_rdata_next;
      host_ack_reg <= (kind_reg != switch_memory_access_pkg::KIND_NONE); // RQ19
    end
  end

  assign host_rdata = host_rdata_reg;
  assign host_ack = host_ack_reg;
  assign fwd_req = fwd_reg;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  sequence data_req_s;
    host_req.valid && host_req.addr[14] && (memory_select_field[2:1] == 2'b01);
  endsequence

  sequence data_answer_s;
    ##2 host_ack;
  endsequence

  reg_space_route_a: assert property (@(posedge core_clk) disable iff (srst) // RQ1
    host_req.valid && !host_req.addr[14] |=> fwd_req.reg_valid
      && !fwd_req.local_route_valid && !fwd_req.backplane_route_valid)
    else $error("register access not routed to register space");

  local_route_sel_a: assert property (@(posedge core_clk) disable iff (srst) // RQ3
    host_req.valid && host_req.addr[14] && (memory_select_field == 3'h0)
      |=> fwd_req.local_route_valid && !fwd_req.reg_valid
        && (fwd_req.addr == $past(host_req.addr[13:0])))
    else $error("select 000 did not reach local route table");

  bp_route_sel_a: assert property (@(posedge core_clk) disable iff (srst) // RQ3
    host_req.valid && host_req.addr[14] && (memory_select_field == 3'h1)
      |=> fwd_req.backplane_route_valid && !fwd_req.local_route_valid)
    else $error("select 001 did not reach backplane route table");

  data_answer_a: assert property (@(posedge core_clk) disable iff (srst) // RQ2
    data_req_s |-> data_answer_s)
    else $error("data store access not answered in two cycles");

  upper_byte_zero_a: assert property (@(posedge core_clk) disable iff (srst) // RQ13
    host_ack |-> host_rdata[15:8] == 8'h00)
    else $error("upper read byte not zero");

  write_ignored_a: assert property (@(posedge core_clk) disable iff (srst) // RQ19
    data_req_s ##0 host_req.we |-> ##2 host_ack && (host_rdata == 16'h0000))
    else $error("data store write not completed as a no-op");

  chan_range_a: assert property (@(posedge core_clk) disable iff (srst) // RQ7
    host_req.valid && host_req.addr[14] && (memory_select_field == 3'h2) && !host_req.we
      && (local_rate == switch_memory_access_pkg::RATE_2M) && (host_req.addr[8:0] > 9'h01F)
      |-> ##2 host_ack && (host_rdata == 16'h0000))
    else $error("unused channel read returned data");

  hi_rate_stream_a: assert property (@(posedge core_clk) disable iff (srst) // RQ5
    host_req.valid && host_req.addr[14] && (memory_select_field == 3'h3)
      && (backplane_rate == switch_memory_access_pkg::RATE_32M) && (host_req.addr[13:9] > 5'h0F)
      |-> ##2 host_rdata == 16'h0000)
    else $error("unused backplane stream read returned data");

  local_stream_a: assert property (@(posedge core_clk) disable iff (srst) // RQ4
    host_req.valid && host_req.addr[14] && (memory_select_field == 3'h2)
      && host_req.addr[13] |-> ##2 host_rdata == 16'h0000)
    else $error("local stream above 15 returned data");

  no_ack_route_a: assert property (@(posedge core_clk) disable iff (srst) // RQ1
    host_req.valid && (!host_req.addr[14] || (memory_select_field[2:1] == 2'b00))
      ##1 !host_req.valid |-> ##1 !host_ack)
    else $error("forwarded access answered locally");

endmodule : switch_memory_access_map

/* include/switch_memory_access_map.svh */
`ifndef SWITCH_MEMORY_ACCESS_MAP_SVH
`define SWITCH_MEMORY_ACCESS_MAP_SVH

// ----------------------------------------
// Host address fields
// ----------------------------------------
`define SPACE_SEL_BIT 14
`define STREAM_MSB 13
`define STREAM_LSB 9
`define CHAN_MSB 8
`define CHAN_LSB 0
`define HOST_ADDR_W 15
`define HOST_DATA_W 16

// ----------------------------------------
// Memory select encodings
// ----------------------------------------
`define MS_LOCAL_ROUTE 3'h0
`define MS_BACKPLANE_ROUTE 3'h1
`define MS_LOCAL_DATA 3'h2
`define MS_BACKPLANE_DATA 3'h3

// ----------------------------------------
// Data store geometry
// ----------------------------------------
`define LOCAL_DEPTH 4096
`define BACKPLANE_DEPTH 8192
`define LOCAL_IDX_W 12
`define BACKPLANE_IDX_W 13
`define BYTE_W 8
`define UPPER_FILL 8'h00
`define LOCAL_STREAMS 5'h10
`define LOCAL_STREAMS_HI 5'h08
`define BACKPLANE_STREAMS_HI 5'h10
`define CHAN_BASE 10'h020
`define READ_LATENCY 2

`endif

/* include/switch_memory_access_pkg.sv */
package switch_memory_access_pkg;

  // ----------------------------------------
  // Serial rates
  // ----------------------------------------
  typedef enum logic [2:0] {
    RATE_2M = 3'b000,
    RATE_4M = 3'b001,
    RATE_8M = 3'b010,
    RATE_16M = 3'b011,
    RATE_32M = 3'b100
  } rate_t;

  typedef enum logic [1:0] {
    KIND_NONE = 2'b00,
    KIND_LOCAL_DATA = 2'b01,
    KIND_BACKPLANE_DATA = 2'b10,
    KIND_UNMAPPED = 2'b11
  } access_kind_t;

  typedef struct packed {
    logic valid;
    logic we;
    logic [14:0] addr;
    logic [15:0] wdata;
  } host_req_t;

  typedef struct packed {
    logic reg_valid;
    logic local_route_valid;
    logic backplane_route_valid;
    logic we;
    logic [13:0] addr;
    logic [15:0] wdata;
  } fwd_req_t;

  typedef struct packed {
    logic valid;
    logic slot_start;
    logic data;
    logic [4:0] stream;
    logic [8:0] chan;
  } rx_bit_t;

  typedef struct packed {
    logic valid;
    logic [4:0] stream;
    logic [8:0] chan;
    logic [7:0] data;
  } rx_byte_t;

endpackage : switch_memory_access_pkg

/* hw/rx_serial_to_byte.sv */
`timescale 1ns/1ns
`include "switch_memory_access_map.svh"

module rx_serial_to_byte (
  input wire logic core_clk,
  input wire logic srst,
  input wire switch_memory_access_pkg::rx_bit_t rx_in,
  output switch_memory_access_pkg::rx_byte_t byte_out
);

  logic [6:0] shift_reg;
  logic [2:0] count_reg;
  logic [4:0] stream_reg;
  logic [8:0] chan_reg;
  logic first_bit_reg;
  switch_memory_access_pkg::rx_byte_t out_reg;
  wire last_bit = rx_in.valid && !rx_in.slot_start && (count_reg == 3'h7);

  // ----------------------------------------
  // Shift in, first bit ends at bit 7
  // ----------------------------------------
  always_ff @(posedge core_clk) begin
    if (srst) begin
      shift_reg <= 7'h00;
      count_reg <= 3'h0;
      stream_reg <= 5'h00;
      chan_reg <= 9'h000;
      first_bit_reg <= 1'b0;
    end else if (rx_in.valid && rx_in.slot_start) begin
      shift_reg <= {6'h00, rx_in.data};
      count_reg <= 3'h1;
      stream_reg <= rx_in.stream;
      chan_reg <= rx_in.chan;
      first_bit_reg <= rx_in.data;
    end else if (rx_in.valid) begin
      shift_reg <= {shift_reg[5:0], rx_in.data}; // RQ14 RQ17
      count_reg <= count_reg + 3'h1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      out_reg <= '0;
    end else begin
      out_reg.valid <= last_bit; // RQ10
      out_reg.stream <= stream_reg;
      out_reg.chan <= chan_reg;
      out_reg.data <= {shift_reg, rx_in.data};
    end
  end

  assign byte_out = out_reg;

  first_bit_msb_a: assert property (@(posedge core_clk) disable iff (srst) // RQ14
    last_bit |=> byte_out.data[7] == $past(first_bit_reg))
    else $error("first received bit not in bit 7");

endmodule : rx_serial_to_byte

/* testbench/host_bus_model.sv */
`timescale 1ns/1ns

module host_bus_model (
  input wire logic core_clk,
  output switch_memory_access_pkg::host_req_t host_req,
  output logic [2:0] memory_select_field,
  input wire logic [15:0] host_rdata,
  input wire logic host_ack,
  input wire switch_memory_access_pkg::fwd_req_t fwd_req
);
  initial begin
    host_req = '0;
    memory_select_field = 3'h0;
  end

  // Latencies count falling edges after the taking edge; 99 flags a repeated pulse
  task automatic access(input logic [2:0] ms, input logic we, input logic [14:0] addr, input logic [15:0] wd,
    output logic [15:0] rd, output int ack_lat, output int fwd_lat,
    output switch_memory_access_pkg::fwd_req_t fwd);
    ack_lat = 0;
    fwd_lat = 0;
    rd = 16'h0000;
    fwd = '0;
    @(posedge core_clk);
    memory_select_field <= ms;
    @(posedge core_clk);
    host_req <= '{1'b1, we, addr, wd};
    @(posedge core_clk);
    // Idle bus shows inverted fields so stale values never pass for a request
    host_req <= '{1'b0, ~we, ~addr, ~wd};
    for (int k = 1; k <= 4; k++) begin
      @(negedge core_clk);
      if (host_ack === 1'b1) begin
        ack_lat = (ack_lat == 0) ? k : 99;
        rd = host_rdata;
      end
      if ((fwd_req.reg_valid | fwd_req.local_route_valid | fwd_req.backplane_route_valid) === 1'b1) begin
        fwd_lat = (fwd_lat == 0) ? k : 99;
        fwd = fwd_req;
      end
    end
  endtask : access
endmodule : host_bus_model

/* testbench/switch_memory_access_map_tb.sv */
`timescale 1ns/1ns

module switch_memory_access_map_tb;
  logic core_clk = 1'b0;
  logic srst = 1'b1;
  switch_memory_access_pkg::host_req_t host_req;
  logic [2:0] memory_select_field;
  switch_memory_access_pkg::rate_t local_rate = switch_memory_access_pkg::RATE_2M;
  switch_memory_access_pkg::rate_t backplane_rate = switch_memory_access_pkg::RATE_2M;
  switch_memory_access_pkg::rx_bit_t local_rx = '0;
  switch_memory_access_pkg::rx_bit_t backplane_rx = '0;
  logic [15:0] host_rdata;
  logic host_ack;
  switch_memory_access_pkg::fwd_req_t fwd_req;
  int fails = 0;
  int n_tests = 0;
  logic [7:0] lmem [int];
  logic [7:0] bmem [int];

  always #4 core_clk = ~core_clk;

  switch_memory_access_map i_switch_memory_access_map (
    .core_clk(core_clk),
    .srst(srst),
    .host_req(host_req),
    .memory_select_field(memory_select_field),
    .local_rate(local_rate),
    .backplane_rate(backplane_rate),
    .local_rx(local_rx),
    .backplane_rx(backplane_rx),
    .host_rdata(host_rdata),
    .host_ack(host_ack),
    .fwd_req(fwd_req)
  );

  host_bus_model i_host_bus_model (
    .core_clk(core_clk),
    .host_req(host_req),
    .memory_select_field(memory_select_field),
    .host_rdata(host_rdata),
    .host_ack(host_ack),
    .fwd_req(fwd_req)
  );

  // ----------------------------------------
  // Checking helpers
  // ----------------------------------------
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  function automatic bit in_use(bit bp, int s, int c, int r);
    int smax;
    smax = bp ? (r == 4 ? 16 : 32) : (r == 4 ? 8 : 16);
    return (c < (32 << r)) && (s < smax);
  endfunction : in_use

  task automatic send_slot(bit bp, int s, int c, logic [7:0] b, int r);
    switch_memory_access_pkg::rx_bit_t x;
    for (int i = 0; i < 8; i++) begin
      @(posedge core_clk);
      x = '{1'b1, i == 0, b[7 - i], s[4:0], c[8:0]};
      if (bp) backplane_rx <= x;
      else local_rx <= x;
    end
    @(posedge core_clk);
    local_rx.valid <= 1'b0;
    backplane_rx.valid <= 1'b0;
    repeat (3) @(posedge core_clk);
    if (in_use(bp, s, c, r) && bp) bmem[s * 512 + c] = b;
    if (in_use(bp, s, c, r) && !bp) lmem[s * 512 + c] = b;
  endtask : send_slot

  // Bytes never received are not predicted, so only filled places are read back
  task automatic acc(logic [2:0] ms, bit we, int s, int c, int r);
    logic [15:0] rd;
    logic [15:0] wd;
    logic [15:0] exp;
    int al;
    int fl;
    int k;
    switch_memory_access_pkg::fwd_req_t fw;
    k = s * 512 + c;
    wd = 16'($urandom);
    exp = 16'h0000;
    if (!we && in_use(ms[0], s, c, r) && ms == 3'h2 && lmem.exists(k)) exp = {8'h00, lmem[k]};
    if (!we && in_use(ms[0], s, c, r) && ms == 3'h3 && bmem.exists(k)) exp = {8'h00, bmem[k]};
    i_host_bus_model.access(ms, we, {1'b1, s[4:0], c[8:0]}, wd, rd, al, fl, fw);
    chk({16'(al), 16'(fl), rd}, {16'h0002, 16'h0000, exp});
  endtask : acc

  task automatic final_report();
    $display("comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : final_report

  initial begin
    repeat (50000) @(posedge core_clk);
    fails++;
    final_report();
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    logic [14:0] a;
    logic [15:0] wd;
    logic [15:0] rd;
    logic we;
    logic [7:0] b;
    int al;
    int fl;
    int s;
    int c;
    int cm;
    switch_memory_access_pkg::fwd_req_t fw;
    void'($urandom(21246));
    repeat (5) @(posedge core_clk);
    srst <= 1'b0;
    @(negedge core_clk);
    chk({host_ack, host_rdata, fwd_req}, 64'h0);
    $display("reset test done");
    for (int i = 0; i < 3; i++) begin
      a = 15'($urandom);
      a[14] = (i != 0);
      wd = 16'($urandom);
      we = 1'($urandom);
      i_host_bus_model.access(i == 0 ? 3'h2 : 3'(i - 1), we, a, wd, rd, al, fl, fw);
      chk({8'(al), 8'(fl), fw.reg_valid, fw.local_route_valid, fw.backplane_route_valid, fw.we, fw.addr, fw.wdata},
        {8'h00, 8'h01, 3'b100 >> i, we, a[13:0], wd});
    end
    $display("forward test done");
    for (int r = 0; r < 5; r++) begin
      @(posedge core_clk);
      local_rate <= switch_memory_access_pkg::rate_t'(r);
      backplane_rate <= switch_memory_access_pkg::rate_t'(r);
      lmem.delete();
      bmem.delete();
      cm = (32 << r) - 1;
      for (int j = 0; j < 3; j++) begin
        s = (j == 0) ? (r == 4 ? 7 : 15) : $urandom_range(r == 4 ? 7 : 15);
        c = (j == 0) ? cm : $urandom_range(cm);
        b = 8'($urandom);
        send_slot(0, s, c, b, r);
        send_slot(1, s, c, ~b, r);
        acc(3'h2, 0, s, c, r);
        acc(3'h3, 0, s, c, r);
        acc(3'h2 + 3'(j % 2), 1, s, c, r);
        acc(3'h2 + 3'(j % 2), 0, s, c, r);
      end
      s = (r == 4) ? 15 : 31;
      send_slot(1, s, cm, 8'($urandom), r);
      acc(3'h3, 0, s, cm, r);
      s = (r == 4) ? 8 : 16;
      send_slot(0, s, 0, 8'hA5, r);
      acc(3'h2, 0, s, 0, r);
      if (cm < 511) acc(3'h3, 0, 0, cm + 1, r);
      if (cm < 511) acc(3'h2, 0, 0, cm + 1, r);
      if (r == 4) acc(3'h3, 0, 16, 0, r);
      $display("rate %0d test done", r);
    end
    for (int m = 4; m < 8; m++) begin
      acc(3'(m), 0, 0, 0, 0);
    end
    $display("unmapped select test done");
    final_report();
  end
endmodule : switch_memory_access_map_tb
